// ### bench/ftf_framer_asserts.sv
// Port checker for the telegram framer, bound at the foot.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ns
module ftf_framer_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic up_valid,
   input wire logic [7:0] up_data,
   input wire logic up_last,
   input wire logic up_ready,
   input wire logic ser_tx_valid,
   input wire logic [7:0] ser_tx_data,
   input wire logic ser_tx_ready,
   input wire logic ser_tx_fail,
   input wire logic trig_a_seen,
   input wire logic service_sel_dev,
   input wire logic service_sel_gw,
   input wire logic collective_mode,
   input wire logic cfg_valid,
   input wire logic [7:0] cfg_length,
   input wire logic [7:0] status_flags_byte,
   input wire logic service_active_flag,
   input wire logic fresh_data_toggle,
   input wire logic warm_start_ok,
   input wire logic [ftf_pkg::RING_AW:0] ring_fill,
   input wire logic [ftf_pkg::RING_AW:0] cmd_fill,
   input wire logic [15:0] cnt_trigger_command_a,
   input wire logic [15:0] cnt_ser_fail
);
   logic [1:0] beat;
   ////////////////////////////////////////////////////////////////////////
   // Beat position inside an upstream telegram
   always_ff @(posedge clk) begin
      if (!rst_n || (up_valid && up_ready && up_last)) begin
         beat <= 2'd0;
      end else if (up_valid && up_ready && beat != 2'd2) begin
         beat <= beat + 2'd1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_flags_beat;
      up_valid && beat == 2'd0;
   endsequence
   sequence s_len_beat;
      up_valid && beat == 2'd1;
   endsequence
   a_service_on: assert property (
      (service_sel_dev || service_sel_gw) [*3] |-> service_active_flag)
      else $error("service flag not set");
   a_service_off: assert property (
      (!service_sel_dev && !service_sel_gw) [*3] |-> !service_active_flag)
      else $error("service flag not cleared");
   a_flags_beat: assert property (
      s_flags_beat |-> (up_data & 8'h5b) == 8'h00 && !up_last)
      else $error("bad status flags byte");
   a_len_cap: assert property (
      s_len_beat |-> up_data != 8'h00 && up_data <= cfg_length && !up_last)
      else $error("bad length byte");
   a_status_rsvd: assert property (
      (status_flags_byte & 8'h5b) == 8'h00)
      else $error("reserved status bit set");
   a_up_hold: assert property (up_valid && !up_ready |=>
      up_valid && $stable(up_data) && $stable(up_last))
      else $error("upstream beat dropped");
   a_tx_hold: assert property (ser_tx_valid && !ser_tx_ready |=>
      ser_tx_valid && $stable(ser_tx_data))
      else $error("serial beat dropped");
   a_trig_count: assert property (trig_a_seen |=>
      cnt_trigger_command_a == $past(cnt_trigger_command_a) + 16'h1)
      else $error("trigger count missed");
   a_fail_count: assert property (ser_tx_fail |=>
      cnt_ser_fail == $past(cnt_ser_fail) + 16'h1)
      else $error("fail count missed");
   a_warm_start: assert property (cfg_valid [*2] |-> warm_start_ok)
      else $error("warm start not shown");
   a_fresh_hold: assert property (
      collective_mode [*2] |-> $stable(fresh_data_toggle))
      else $error("toggle moved in collective mode");
   a_ring_bound: assert property (
      ring_fill <= 11'd1024 && cmd_fill <= 11'd1024)
      else $error("fill level out of range");
endmodule // ftf_framer_asserts
bind ftf_framer ftf_framer_asserts ftf_framer_asserts_i (.*);

// ### bench/ftf_plc_model.sv
// PLC model: sends control telegrams, takes status telegrams.
// Assumes the framer's valid/ready byte streams and one clock.
`timescale 1ns/1ns
module ftf_plc_model (
   input wire logic clk,
   input wire logic rst_n,
   output logic dn_valid,
   output logic [7:0] dn_data,
   output logic dn_last,
   input wire logic dn_ready,
   input wire logic up_valid,
   input wire logic [7:0] up_data,
   input wire logic up_last,
   output logic up_ready,
   input wire logic plc_stall
);
   logic [7:0] got [0:255];
   logic [15:0] rnd = 16'hace1;
   logic fresh = 1'b0;
   int got_n = 0;
   ////////////////////////////////////////////////////////////////////////
   // Idle levels at time zero
   initial begin
      dn_valid = 1'b0;
      dn_data = 8'h00;
      dn_last = 1'b0;
      up_ready = 1'b0;
   end
   // Random acceptance; every taken status byte kept in order
   always @(posedge clk) begin
      rnd <= {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      up_ready <= rst_n && !plc_stall && rnd[0];
      if (up_valid && up_ready) begin
         got[got_n[7:0]] <= up_data;
         got_n <= got_n + 1;
      end
   end
   // Two header bytes, then data; last marks the final data byte
   task automatic send_tel(input logic cmd, input logic [7:0] rsv,
         input logic [63:0] d, input int n);
      logic [7:0] b;
      fresh = !fresh;
      for (int i = 0; i < n + 2; i++) begin
         b = i == 0 ? {fresh, rnd[6:1], cmd} : rsv;
         if (i > 1) begin
            b = d[8 * i - 16 +: 8];
         end
         dn_valid <= 1'b1;
         dn_data <= b;
         dn_last <= i == n + 1;
         @(posedge clk);
         while (!dn_ready) @(posedge clk);
      end
      dn_valid <= 1'b0;
      dn_last <= 1'b0;
   endtask
endmodule // ftf_plc_model

// ### bench/tb_ftf_framer.sv
// Self-checking bench for the telegram framer.
// Assumes the PLC model and the bound port checker.
`timescale 1ns/1ns
module tb_ftf_framer;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic dn_valid, dn_last, dn_ready, up_valid, up_last, up_ready;
   logic [7:0] dn_data, up_data, ser_tx_data;
   logic ser_tx_valid, service_active_flag, data_lost_flag;
   logic fresh_data_toggle, warm_start_ok;
   logic [7:0] status_flags_byte, status_length_byte;
   logic [ftf_pkg::RING_AW:0] ring_fill, cmd_fill;
   logic [15:0] cnt_rx_frames, cnt_rx_frame_err, cnt_trigger_command_a;
   logic [15:0] cnt_trigger_command_b, cnt_invalid_cmd, cnt_ser_sent;
   logic [15:0] cnt_bus_sent, cnt_ser_fail, cnt_ser_good;
   logic ser_tx_ready = 1'b0, ser_tx_done = 1'b0, ser_tx_fail = 1'b0;
   logic ser_rx_valid = 1'b0, ser_rx_last = 1'b0, ser_rx_frame_err = 1'b0;
   logic [7:0] ser_rx_data = 8'h00;
   logic trig_a_seen = 1'b0, trig_b_seen = 1'b0, bad_cmd_seen = 1'b0;
   logic service_sel_dev = 1'b0, service_sel_gw = 1'b1;
   logic collective_mode = 1'b0, cfg_valid = 1'b1, plc_stall = 1'b0;
   logic [7:0] cfg_length = 8'h08;
   logic [7:0] cfg_start_chr = ftf_pkg::CHR_START_DEFAULT;
   logic [7:0] cfg_end1_chr = ftf_pkg::CHR_END1_DEFAULT;
   logic [7:0] cfg_end2_chr = ftf_pkg::CHR_END2_DEFAULT;
   logic [31:0] seed = 32'hf4936131;
   logic [7:0] tx_got [0:255];
   logic [7:0] exp_q [$];
   int tx_n = 0, rd = 0, tels = 0, tog_n = 0, checks = 0, bad_count = 0;
   int ea = 0, eb = 0, ebad = 0, efail = 0, egood = 0, eerr = 0;
   ftf_framer ftf_framer_i (.*);
   ftf_plc_model ftf_plc_model_i (.*);
   ////////////////////////////////////////////////////////////////////////
   // Clock and serial sink with random stalls
   initial forever #5 clk = !clk;
   always @(posedge clk) begin
      ser_tx_ready <= !ser_tx_ready || seed[2];
      if (ser_tx_valid && ser_tx_ready) begin
         tx_got[tx_n[7:0]] <= ser_tx_data;
         tx_n <= tx_n + 1;
      end
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected serial byte j of a frame carrying n data bytes
   function automatic logic [7:0] exp_tx(input logic [63:0] d, input int n,
         input int j);
      if (j == 0) return cfg_start_chr;
      if (j <= n) return d[8 * j - 8 +: 8];
      return j == n + 1 ? cfg_end1_chr : cfg_end2_chr;
   endfunction
   function automatic logic [7:0] up_b(input int i);
      return ftf_plc_model_i.got[i[7:0]];
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One PLC telegram, then the serial frame or its absence
   task automatic down(input logic cmd, input int n);
      logic [63:0] d;
      int base;
      seed = lfsr_next(seed);
      d = {seed, lfsr_next(seed)};
      base = tx_n;
      ftf_plc_model_i.send_tel(cmd, seed[15:8], d, n);
      for (int i = 0; i < 300 && tx_n < base + n + 3; i++) @(posedge clk);
      if (cmd) begin
         chk("tx count", 16'(tx_n - base), 16'h0);
         chk("cmd fill", 16'(cmd_fill), 16'(n));
      end else begin
         for (int j = 0; j < n + 3; j++) begin
            chk("tx byte", tx_got[base + j], exp_tx(d, n, j));
         end
         ser_tx_done <= 1'b1;
         egood++;
         @(posedge clk);
         ser_tx_done <= 1'b0;
      end
   endtask
   task automatic push_rx(input int n);
      for (int i = 0; i < n; i++) begin
         seed = lfsr_next(seed);
         exp_q.push_back(seed[7:0]);
         ser_rx_valid <= 1'b1;
         ser_rx_data <= seed[7:0];
         ser_rx_last <= i == n - 1;
         @(posedge clk);
      end
      ser_rx_valid <= 1'b0;
      ser_rx_last <= 1'b0;
      @(posedge clk);
   endtask
   // Let the PLC take all, then parse status telegrams
   task automatic drain(input logic loss_exp);
      logic loss;
      int len;
      logic [7:0] f;
      loss = 1'b0;
      plc_stall <= 1'b0;
      for (int i = 0; i < 600 && (ring_fill != 0 || up_valid); i++) begin
         @(posedge clk);
      end
      repeat (10) @(posedge clk);
      while (rd < ftf_plc_model_i.got_n) begin
         len = up_b(rd + 1);
         f = up_b(rd);
         loss = loss | f[ftf_pkg::STS_LOST_BIT];
         chk("svc bit", f[ftf_pkg::STS_SERVICE_BIT], 1'b1);
         chk("nd", f[ftf_pkg::STS_FRESH_BIT],
            !collective_mode && !tog_n[0]);
         for (int j = 0; j < len; j++) begin
            chk("up byte", up_b(rd + 2 + j), exp_q.pop_front());
         end
         rd += len + 2;
         tels++;
         tog_n += int'(!collective_mode);
      end
      chk("loss", loss, loss_exp);
      chk("len", status_length_byte, 16'(len));
      chk("left", 16'(exp_q.size()), 16'h0);
      chk("bus sent", cnt_bus_sent, 16'(tels));
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      close_out;
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      chk("flags rst", status_flags_byte, 8'h00);
      @(posedge clk);
      for (int k = 0; k < 5; k++) begin
         seed = lfsr_next(seed);
         down(1'b0, k == 0 ? 8 : 1 + int'(seed[2:0]));
         @(posedge clk);
      end
      chk("ser sent", cnt_ser_sent, 16'h5);
      down(1'b1, 5);
      cfg_length <= 8'h04;
      plc_stall <= 1'b1;
      push_rx(11);
      drain(1'b1);
      chk("frames", cnt_rx_frames, 16'h1);
      push_rx(2);
      drain(1'b0);
      chk("lost", data_lost_flag, 1'b0);
      chk("toggle", fresh_data_toggle, tog_n[0]);
      collective_mode <= 1'b1;
      push_rx(3);
      drain(1'b0);
      chk("toggle col", fresh_data_toggle, tog_n[0]);
      for (int i = 0; i < 24; i++) begin
         seed = lfsr_next(seed);
         {ser_rx_frame_err, trig_a_seen, trig_b_seen, bad_cmd_seen} <=
            seed[5:2];
         {ser_tx_fail, ser_tx_done} <= seed[1:0];
         eerr += seed[5];
         ea += seed[4];
         eb += seed[3];
         ebad += seed[2];
         efail += seed[1];
         egood += seed[0];
         @(posedge clk);
      end
      {ser_rx_frame_err, trig_a_seen, trig_b_seen, bad_cmd_seen} <= 4'h0;
      {ser_tx_fail, ser_tx_done} <= 2'h0;
      repeat (2) @(posedge clk);
      chk("trig a", cnt_trigger_command_a, 16'(ea));
      chk("trig b", cnt_trigger_command_b, 16'(eb));
      chk("invalid", cnt_invalid_cmd, 16'(ebad));
      chk("ferr", cnt_rx_frame_err, 16'(eerr));
      chk("fail", cnt_ser_fail, 16'(efail));
      chk("good", cnt_ser_good, 16'(egood));
      cfg_valid <= 1'b0;
      service_sel_gw <= 1'b0;
      repeat (3) @(posedge clk);
      chk("warm off", warm_start_ok, 1'b0);
      chk("svc off", service_active_flag, 1'b0);
      cfg_valid <= 1'b1;
      service_sel_dev <= 1'b1;
      repeat (3) @(posedge clk);
      chk("warm on", warm_start_ok, 1'b1);
      chk("svc on", service_active_flag, 1'b1);
      close_out;
   end
endmodule // tb_ftf_framer

// ### rtl/ftf_fifo.sv
// Parameterised valid/ready FIFO used in the downstream data path of the framer.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ns
module ftf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [AW:0] level
);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } ftf_fifo_st_t;

   ftf_fifo_st_t st;
   ftf_fifo_st_t next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Handshakes and honest flags
   assign in_ready = (st.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st.cnt != '0);
   assign out_data = mem[st.rd];
   assign level = st.cnt;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer and count update
   always_comb begin
      next_st = st;
      if (push) next_st.wr = st.wr + 1'b1;
      if (pop) next_st.rd = st.rd + 1'b1;
      if (push && !pop) next_st.cnt = st.cnt + 1'b1;
      if (pop && !push) next_st.cnt = st.cnt - 1'b1;
   end

   // State register and storage write
   always_ff @(posedge clk) begin
      if (!rst_n) st <= '0;
      else st <= next_st;
      if (push) mem[st.wr] <= in_data;
   end
endmodule // ftf_fifo

// ### rtl/ftf_framer.sv
// Telegram framer between a PLC byte stream and a serial end device.
// Assumes byte-wide valid/ready streams on both sides, synchronous inputs,
// and that the serial receiver marks frame ends and framing errors.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module ftf_framer (
   input wire logic clk,
   input wire logic rst_n,
   // PLC to device telegram stream
   input wire logic dn_valid,
   input wire logic [7:0] dn_data,
   input wire logic dn_last,
   output logic dn_ready,
   // Device to PLC telegram stream
   output logic up_valid,
   output logic [7:0] up_data,
   output logic up_last,
   input wire logic up_ready,
   // Serial transmit byte stream
   output logic ser_tx_valid,
   output logic [7:0] ser_tx_data,
   input wire logic ser_tx_ready,
   input wire logic ser_tx_done,
   input wire logic ser_tx_fail,
   // Serial receive byte stream
   input wire logic ser_rx_valid,
   input wire logic [7:0] ser_rx_data,
   input wire logic ser_rx_last,
   input wire logic ser_rx_frame_err,
   // Command classification strobes from the serial side
   input wire logic trig_a_seen,
   input wire logic trig_b_seen,
   input wire logic bad_cmd_seen,
   // Configuration and selectors
   input wire logic service_sel_dev,
   input wire logic service_sel_gw,
   input wire logic collective_mode,
   input wire logic cfg_valid,
   input wire logic [7:0] cfg_length,
   input wire logic [7:0] cfg_start_chr,
   input wire logic [7:0] cfg_end1_chr,
   input wire logic [7:0] cfg_end2_chr,
   // Status and diagnostics
   output logic [7:0] status_flags_byte,
   output logic [7:0] status_length_byte,
   output logic service_active_flag,
   output logic data_lost_flag,
   output logic fresh_data_toggle,
   output logic warm_start_ok,
   output logic [ftf_pkg::RING_AW:0] ring_fill,
   output logic [ftf_pkg::RING_AW:0] cmd_fill,
   output logic [15:0] cnt_rx_frames,
   output logic [15:0] cnt_rx_frame_err,
   output logic [15:0] cnt_trigger_command_a,
   output logic [15:0] cnt_trigger_command_b,
   output logic [15:0] cnt_invalid_cmd,
   output logic [15:0] cnt_ser_sent,
   output logic [15:0] cnt_bus_sent,
   output logic [15:0] cnt_ser_fail,
   output logic [15:0] cnt_ser_good
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      ftf_pkg::ftf_tx_state_t tx;
      ftf_pkg::ftf_up_state_t up;
      logic [1:0] hdr_idx;
      logic cmd_mode;
      logic [7:0] sent;
      logic [7:0] up_left;
      logic [7:0] status_flags_byte;
      logic [7:0] status_length_byte;
      logic service_active_flag;
      logic data_lost_flag;
      logic fresh_data_toggle;
      logic warm_start_ok;
      logic [7:0] up_data;
      logic up_valid;
      logic up_last;
      logic [7:0] ser_tx_data;
      logic ser_tx_valid;
      logic [ftf_pkg::RING_AW:0] ring_fill;
      logic [ftf_pkg::RING_AW:0] cmd_fill;
      logic [15:0] c_rx;
      logic [15:0] c_err;
      logic [15:0] c_ta;
      logic [15:0] c_tb;
      logic [15:0] c_bad;
      logic [15:0] c_sent;
      logic [15:0] c_bus;
      logic [15:0] c_fail;
      logic [15:0] c_good;
   } ftf_st_t;

   ftf_st_t st;
   ftf_st_t next_st;

   // Downstream data FIFO and ring wiring
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [8:0] fifo_out;
   logic [ftf_pkg::FIFO_AW:0] fifo_level;
   logic ring_wr;
   logic ring_full;
   logic ring_rd;
   logic [7:0] ring_data;
   logic ring_empty;
   logic [ftf_pkg::RING_AW:0] ring_lvl;
   logic cmd_wr;
   logic cmd_full;
   logic cmd_rd;
   logic [7:0] cmd_data;
   logic cmd_empty;
   logic [ftf_pkg::RING_AW:0] cmd_lvl;
   logic dn_data_phase;
   logic dn_hdr0;

   ////////////////////////////////////////////////////////////////////////
   // Header bytes are consumed here, data bytes go to the FIFO
   assign dn_hdr0 = (st.hdr_idx == 2'd0);
   assign dn_data_phase = (st.hdr_idx == 2'd2);
   assign fifo_in_valid = dn_valid && dn_data_phase;
   assign dn_ready = dn_data_phase ? fifo_in_ready : 1'b1;

   ftf_fifo #(
      .WIDTH(9),
      .DEPTH(ftf_pkg::FIFO_DEPTH),
      .AW(ftf_pkg::FIFO_AW)
   ) u_dn_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data({dn_last, dn_data}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out),
      .level(fifo_level)
   );

   // Command mode diverts data into the command ring
   assign fifo_out_ready = st.cmd_mode ? !cmd_full
      : (st.tx == ftf_pkg::TX_DATA && !st.ser_tx_valid);
   assign cmd_wr = fifo_out_valid && st.cmd_mode;
   assign cmd_rd = 1'b0;

   ftf_ring u_cmd_ring (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(cmd_wr),
      .wr_data(fifo_out[7:0]),
      .full(cmd_full),
      .rd_en(cmd_rd),
      .rd_data(cmd_data),
      .empty(cmd_empty),
      .fill(cmd_lvl)
   );

   // Serial bytes without framing error are buffered toward the bus in every mode
   assign ring_wr = ser_rx_valid && !ser_rx_frame_err;
   assign ring_rd = (st.up == ftf_pkg::UP_DATA) && !st.up_valid
      && (st.up_left != 8'h00);

   ftf_ring u_up_ring (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(ring_wr),
      .wr_data(ser_rx_data),
      .full(ring_full),
      .rd_en(ring_rd),
      .rd_data(ring_data),
      .empty(ring_empty),
      .fill(ring_lvl)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic [ftf_pkg::RING_AW:0] take;
      logic over;
      take = '0;
      over = 1'b0;
      next_st = st;
      // Control byte parse, reserved byte and bits ignored
      if (dn_valid && dn_ready && !dn_data_phase) begin
         if (dn_hdr0) begin
            next_st.cmd_mode = dn_data[ftf_pkg::CTL_CMD_BIT];
         end
         next_st.hdr_idx = st.hdr_idx + 2'd1;
      end
      if (dn_valid && dn_ready && dn_data_phase && dn_last) begin
         next_st.hdr_idx = 2'd0;
      end
      // Serial forward sequencer with framing characters
      if (st.ser_tx_valid && ser_tx_ready) next_st.ser_tx_valid = 1'b0;
      unique case (st.tx)
         ftf_pkg::TX_IDLE: begin
            if (fifo_out_valid && !st.cmd_mode && !st.ser_tx_valid) begin
               next_st.ser_tx_data = cfg_start_chr;
               next_st.ser_tx_valid = 1'b1;
               next_st.tx = ftf_pkg::TX_DATA;
            end
         end
         ftf_pkg::TX_START: next_st.tx = ftf_pkg::TX_DATA;
         ftf_pkg::TX_DATA: begin
            if (fifo_out_valid && fifo_out_ready) begin
               next_st.ser_tx_data = fifo_out[7:0];
               next_st.ser_tx_valid = 1'b1;
               if (fifo_out[8]) next_st.tx = ftf_pkg::TX_END1;
            end
         end
         ftf_pkg::TX_END1: begin
            if (!st.ser_tx_valid) begin
               next_st.ser_tx_data = cfg_end1_chr;
               next_st.ser_tx_valid = 1'b1;
               next_st.tx = ftf_pkg::TX_END2;
            end
         end
         ftf_pkg::TX_END2: begin
            if (!st.ser_tx_valid) begin
               next_st.ser_tx_data = cfg_end2_chr;
               next_st.ser_tx_valid = 1'b1;
               next_st.tx = ftf_pkg::TX_IDLE;
               next_st.c_sent = st.c_sent + 16'h0001;
            end
         end
      endcase
      // Status byte 0, reserved bits held at zero
      next_st.service_active_flag = service_sel_dev || service_sel_gw;
      next_st.status_flags_byte = ftf_pkg::STS_FLAGS_RESET;
      next_st.status_flags_byte[ftf_pkg::STS_SERVICE_BIT] =
         st.service_active_flag;
      next_st.status_flags_byte[ftf_pkg::STS_LOST_BIT] = st.data_lost_flag;
      next_st.status_flags_byte[ftf_pkg::STS_FRESH_BIT] =
         collective_mode ? 1'b0 : st.fresh_data_toggle;
      // Upstream telegram builder
      if (st.up_valid && up_ready) next_st.up_valid = 1'b0;
      unique case (st.up)
         ftf_pkg::UP_IDLE: begin
            if (!ring_empty && !st.up_valid) begin
               over = (ring_lvl > {3'b000, cfg_length});
               take = over ? {3'b000, cfg_length} : ring_lvl;
               next_st.status_length_byte = take[7:0];
               next_st.data_lost_flag = over;
               if (!collective_mode) begin
                  next_st.fresh_data_toggle = !st.fresh_data_toggle;
               end
               next_st.up = ftf_pkg::UP_HDR0;
            end
         end
         ftf_pkg::UP_HDR0: begin
            if (!st.up_valid) begin
               next_st.up_data = next_st.status_flags_byte;
               next_st.up_valid = 1'b1;
               next_st.up_last = 1'b0;
               next_st.up = ftf_pkg::UP_HDR1;
            end
         end
         ftf_pkg::UP_HDR1: begin
            if (!st.up_valid) begin
               next_st.up_data = st.status_length_byte;
               next_st.up_valid = 1'b1;
               next_st.up_last = (st.status_length_byte == 8'h00);
               next_st.up_left = st.status_length_byte;
               next_st.up = ftf_pkg::UP_DATA;
            end
         end
         ftf_pkg::UP_DATA: begin
            if (ring_rd) begin
               next_st.up_data = ring_data;
               next_st.up_valid = 1'b1;
               next_st.up_last = (st.up_left == 8'h01);
               next_st.up_left = st.up_left - 8'h01;
            end else if (!st.up_valid && st.up_left == 8'h00) begin
               next_st.c_bus = st.c_bus + 16'h0001;
               next_st.up = ftf_pkg::UP_IDLE;
            end
         end
      endcase
      next_st.warm_start_ok = cfg_valid;
      next_st.ring_fill = ring_lvl;
      next_st.cmd_fill = cmd_lvl;
      // Diagnostic counters
      if (ser_rx_valid && ser_rx_last) next_st.c_rx = st.c_rx + 16'h0001;
      if (ser_rx_frame_err) next_st.c_err = st.c_err + 16'h0001;
      if (trig_a_seen) next_st.c_ta = st.c_ta + 16'h0001;
      if (trig_b_seen) next_st.c_tb = st.c_tb + 16'h0001;
      if (bad_cmd_seen) next_st.c_bad = st.c_bad + 16'h0001;
      if (ser_tx_fail) next_st.c_fail = st.c_fail + 16'h0001;
      if (ser_tx_done) next_st.c_good = st.c_good + 16'h0001;
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
         st.tx <= ftf_pkg::TX_IDLE;
         st.up <= ftf_pkg::UP_IDLE;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign up_valid = st.up_valid;
   assign up_data = st.up_data;
   assign up_last = st.up_last;
   assign ser_tx_valid = st.ser_tx_valid;
   assign ser_tx_data = st.ser_tx_data;
   assign status_flags_byte = st.status_flags_byte;
   assign status_length_byte = st.status_length_byte;
   assign service_active_flag = st.service_active_flag;
   assign data_lost_flag = st.data_lost_flag;
   assign fresh_data_toggle = st.fresh_data_toggle;
   assign warm_start_ok = st.warm_start_ok;
   assign ring_fill = st.ring_fill;
   assign cmd_fill = st.cmd_fill;
   assign cnt_rx_frames = st.c_rx;
   assign cnt_rx_frame_err = st.c_err;
   assign cnt_trigger_command_a = st.c_ta;
   assign cnt_trigger_command_b = st.c_tb;
   assign cnt_invalid_cmd = st.c_bad;
   assign cnt_ser_sent = st.c_sent;
   assign cnt_bus_sent = st.c_bus;
   assign cnt_ser_fail = st.c_fail;
   assign cnt_ser_good = st.c_good;
endmodule // ftf_framer

// ### rtl/ftf_pkg.sv
// Constants and state types of the fieldbus telegram framer.
// Assumes a single 100 MHz clock domain and synchronous active-low reset.
package ftf_pkg;
   // Status byte 0 fields
   localparam int STS_SERVICE_BIT = 2;
   localparam int STS_LOST_BIT = 5;
   localparam int STS_FRESH_BIT = 7;
   // Control byte 0 fields
   localparam int CTL_CMD_BIT = 0;
   localparam int CTL_BCAST_BIT = 1;
   localparam int CTL_ADDR_LSB = 2;
   localparam int CTL_ADDR_MSB = 6;
   localparam int CTL_FRESH_BIT = 7;
   // Ring memory sizing
   localparam int RING_DEPTH = 1024;
   localparam int RING_AW = 10;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   // Reset values
   localparam logic [7:0] STS_FLAGS_RESET = 8'h00;
   localparam logic [7:0] LEN_RESET = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   // Default configured payload length and serial framing
   localparam logic [7:0] CFG_LEN_DEFAULT = 8'h08;
   localparam logic [7:0] CHR_START_DEFAULT = 8'h02;
   localparam logic [7:0] CHR_END1_DEFAULT = 8'h0d;
   localparam logic [7:0] CHR_END2_DEFAULT = 8'h0a;

   // Fieldbus-to-serial forwarding states
   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001,
      TX_START = 5'b00010,
      TX_DATA = 5'b00100,
      TX_END1 = 5'b01000,
      TX_END2 = 5'b10000
   } ftf_tx_state_t;

   // Serial-to-fieldbus telegram states
   typedef enum logic [3:0] {
      UP_IDLE = 4'b0001,
      UP_HDR0 = 4'b0010,
      UP_HDR1 = 4'b0100,
      UP_DATA = 4'b1000
   } ftf_up_state_t;
endpackage

// ### rtl/ftf_ring.sv
// Byte ring memory with fill level, up to 1024 bytes.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ns
module ftf_ring (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic full,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   output logic empty,
   output logic [ftf_pkg::RING_AW:0] fill
);
   typedef struct packed {
      logic [ftf_pkg::RING_AW-1:0] wr;
      logic [ftf_pkg::RING_AW-1:0] rd;
      logic [ftf_pkg::RING_AW:0] cnt;
   } ftf_ring_st_t;

   ftf_ring_st_t st;
   ftf_ring_st_t next_st;
   logic [7:0] mem [ftf_pkg::RING_DEPTH];
   logic push;
   logic pop;

   // Flags, pushes are refused when full
   assign full = (st.cnt == (ftf_pkg::RING_AW+1)'(ftf_pkg::RING_DEPTH));
   assign empty = (st.cnt == '0);
   assign rd_data = mem[st.rd];
   assign fill = st.cnt;
   assign push = wr_en && !full;
   assign pop = rd_en && !empty;

   // Pointer and level update
   always_comb begin
      next_st = st;
      if (push) next_st.wr = st.wr + 1'b1;
      if (pop) next_st.rd = st.rd + 1'b1;
      if (push && !pop) next_st.cnt = st.cnt + 1'b1;
      if (pop && !push) next_st.cnt = st.cnt - 1'b1;
   end

   // State register and storage write
   always_ff @(posedge clk) begin
      if (!rst_n) st <= '0;
      else st <= next_st;
      if (push) mem[st.wr] <= wr_data;
   end
endmodule // ftf_ring
